// ---- secure_wp_pkg.sv ----
// constants, request kinds and register layout of the secure write-protect control
package secure_wp_pkg;

  // ****************************************
  // register map of the authenticated area
  // ****************************************
  localparam logic [7:0] ENABLE_BYTE_OFFSET = 8'h01;
  localparam logic [7:0] CONFIG_BYTE_OFFSET = 8'h02;
  localparam logic [7:0] ENABLE_BYTE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_BYTE_RESET = 8'h00;
  localparam int ENABLE_BIT_POS = 0;
  localparam int UPDATE_BIT_POS = 0;
  localparam int USER_WP_TYPE_HI_POS = 2;
  localparam int USER_WP_TYPE_LO_POS = 0;

  // ****************************************
  // answer error bits
  // ****************************************
  localparam int ERR_GENERIC_POS = 0;
  localparam int ERR_SWITCH_POS = 1;
  localparam int ERR_LOCK_POS = 2;
  localparam int ERR_WIDTH = 3;

  // ****************************************
  // synchroniser and reset values
  // ****************************************
  localparam int SYNC_STAGES = 3;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] ERR_RESET = 3'h0;

  typedef enum logic [3:0] {
    REQ_CFG_READ = 4'h0,
    REQ_CFG_WRITE = 4'h1,
    REQ_CSD_PROGRAM = 4'h2,
    REQ_SWITCH_PROTECT = 4'h3,
    REQ_SET_GROUP = 4'h4,
    REQ_CLEAR_GROUP = 4'h5,
    REQ_FORCE_ERASE = 4'h6,
    REQ_READ_EXT = 4'h7,
    REQ_GO_IDLE = 4'h8
  } req_kind_t;

endpackage

// ---- secure_wp_ctrl.sv ----
// secure write-protect mode control with link-side request port
`timescale 1ns/1ps
// ****************************************
// Overview of operation
// - host enters secure mode writing 0x1 to enable bit 0, authenticated only
// - authenticated configuration read returns the enable byte contents
// - entering or leaving secure mode leaves existing protected areas untouched
// - enable bit 0 gives legacy mode: protect updates by CMD27 and CMD6 allowed
// - enable bit 1 makes protect field access depend on the update bit
// - update bit is config bit 0, default 0, gates all five protect fields
// - update bit 0: CMD27 setting temporary or permanent field gives generic error
// - update bit 0: CMD6 to user, boot or boot state field gives switch error
// - update bit 0: force erase refused, stays locked, lock failure flagged
// - update bit 0: CMD28 or CMD29 answered with generic error
// - update bit 0: power-on protected boot partitions stay protected over resets
// - boot protect state field survives power cycle, hardware reset and CMD0
// - update bit 1: protect fields reachable through CMD6, CMD8 and CMD27
// - update bit 1: accepted force erase wipes everything and unlocks
// - update bit 1: force erase refused when power-on or permanent groups exist
// - force erase on an unlocked device refused with lock failure flag
// - update bit 1: CMD28 protects group with type from user field bits 2,0
// - update bit 1: temporary groups and boot partitions temporarily writable
// - power-on and permanent user groups stay protected even with update bit 1
// - clearing update bit, power loss, hardware reset or CMD0 restores protection
// ****************************************
module secure_wp_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_clk_link,
  input wire logic i_req_valid,
  input wire logic [3:0] i_req_kind,
  input wire logic i_req_auth,
  input wire logic [7:0] i_req_addr,
  input wire logic [7:0] i_req_data,
  input wire logic i_locked,
  input wire logic i_hard_groups_exist,
  output logic o_req_busy,
  output logic o_rsp_valid,
  output logic o_rsp_ok,
  output logic [7:0] o_rsp_data,
  output logic [2:0] o_rsp_err,
  output logic o_secure_mode,
  output logic o_update_allow,
  output logic o_temp_unprotect,
  output logic o_erase_all,
  output logic o_unlock
);

  // ****************************************
  // link domain: request capture and answer return
  // ****************************************
  typedef struct packed {
    logic req_tog;
    logic busy;
    logic [3:0] kind;
    logic auth;
    logic [7:0] addr;
    logic [7:0] data;
    logic [2:0] ack_sync;
    logic rsp_valid;
    logic rsp_ok;
    logic [7:0] rsp_data;
    logic [2:0] rsp_err;
  } link_state_t;

  // ****************************************
  // system domain: protection state and decisions
  // ****************************************
  typedef struct packed {
    logic [2:0] req_sync;
    logic ack_tog;
    logic [7:0] enable;
    logic [7:0] config_b;
    logic rsp_ok;
    logic [7:0] rsp_data;
    logic [2:0] rsp_err;
    logic secure;
    logic allow;
    logic temp_unprot;
    logic erase_all;
    logic unlock;
  } sys_state_t;

  link_state_t l_reg;
  link_state_t l_next;
  sys_state_t s_reg;
  sys_state_t s_next;
  logic req_edge;
  logic ack_edge;

  function automatic logic [2:0] err_bit(input int pos);
    err_bit = 3'h0;
    err_bit[pos] = 1'b1;
  endfunction

  assign ack_edge = l_reg.ack_sync[1] ^ l_reg.ack_sync[2];
  assign req_edge = s_reg.req_sync[1] ^ s_reg.req_sync[2];

  // request fields stay frozen while busy, so the toggle is the only crossing event
  always_comb begin
    l_next = l_reg;
    l_next.ack_sync = {l_reg.ack_sync[1:0], s_reg.ack_tog};
    l_next.rsp_valid = 1'b0;
    if (i_req_valid && !l_reg.busy) begin
      l_next.kind = i_req_kind;
      l_next.auth = i_req_auth;
      l_next.addr = i_req_addr;
      l_next.data = i_req_data;
      l_next.busy = 1'b1;
      l_next.req_tog = ~l_reg.req_tog;
    end
    if (ack_edge) begin
      l_next.busy = 1'b0;
      l_next.rsp_valid = 1'b1;
      l_next.rsp_ok = s_reg.rsp_ok;
      l_next.rsp_data = s_reg.rsp_data;
      l_next.rsp_err = s_reg.rsp_err;
    end
  end

  always_ff @(posedge i_clk_link or negedge i_rstn) begin
    if (!i_rstn) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.req_sync = {s_reg.req_sync[1:0], l_reg.req_tog};
    s_next.erase_all = 1'b0;
    s_next.unlock = 1'b0;
    if (req_edge) begin
      s_next.ack_tog = ~s_reg.ack_tog;
      s_next.rsp_ok = 1'b1;
      s_next.rsp_err = secure_wp_pkg::ERR_RESET;
      s_next.rsp_data = secure_wp_pkg::DATA_RESET;
      case (l_reg.kind)
        secure_wp_pkg::REQ_CFG_READ: begin
          if (!l_reg.auth) begin
            s_next.rsp_ok = 1'b0;
            s_next.rsp_err = err_bit(secure_wp_pkg::ERR_GENERIC_POS);
          end else if (l_reg.addr == secure_wp_pkg::ENABLE_BYTE_OFFSET) begin
            s_next.rsp_data = s_reg.enable;
          end else if (l_reg.addr == secure_wp_pkg::CONFIG_BYTE_OFFSET) begin
            s_next.rsp_data = s_reg.config_b;
          end else begin
            s_next.rsp_ok = 1'b0;
            s_next.rsp_err = err_bit(secure_wp_pkg::ERR_GENERIC_POS);
          end
        end
        secure_wp_pkg::REQ_CFG_WRITE: begin
          if (!l_reg.auth) begin
            s_next.rsp_ok = 1'b0;
            s_next.rsp_err = err_bit(secure_wp_pkg::ERR_GENERIC_POS);
          end else if (l_reg.addr == secure_wp_pkg::ENABLE_BYTE_OFFSET) begin
            s_next.enable = {7'h00, l_reg.data[secure_wp_pkg::ENABLE_BIT_POS]};
          end else if (l_reg.addr == secure_wp_pkg::CONFIG_BYTE_OFFSET) begin
            s_next.config_b = {7'h00, l_reg.data[secure_wp_pkg::UPDATE_BIT_POS]};
          end else begin
            s_next.rsp_ok = 1'b0;
            s_next.rsp_err = err_bit(secure_wp_pkg::ERR_GENERIC_POS);
          end
        end
        secure_wp_pkg::REQ_CSD_PROGRAM,
        secure_wp_pkg::REQ_SET_GROUP,
        secure_wp_pkg::REQ_CLEAR_GROUP: begin
          if (s_reg.secure && !s_reg.allow) begin
            s_next.rsp_ok = 1'b0;
            s_next.rsp_err = err_bit(secure_wp_pkg::ERR_GENERIC_POS);
          end else if (l_reg.kind == secure_wp_pkg::REQ_SET_GROUP) begin
            // protection type from user field bits
            s_next.rsp_data = {6'h00, l_reg.data[secure_wp_pkg::USER_WP_TYPE_HI_POS],
                               l_reg.data[secure_wp_pkg::USER_WP_TYPE_LO_POS]};
          end
        end
        secure_wp_pkg::REQ_SWITCH_PROTECT: begin
          if (s_reg.secure && !s_reg.allow) begin
            s_next.rsp_ok = 1'b0;
            s_next.rsp_err = err_bit(secure_wp_pkg::ERR_SWITCH_POS);
          end
        end
        secure_wp_pkg::REQ_FORCE_ERASE: begin
          if (!i_locked || (s_reg.secure && !s_reg.allow)
              || (s_reg.secure && i_hard_groups_exist)) begin
            s_next.rsp_ok = 1'b0;
            s_next.rsp_err = err_bit(secure_wp_pkg::ERR_LOCK_POS);
          end else begin
            s_next.erase_all = 1'b1;
            s_next.unlock = 1'b1;
          end
        end
        secure_wp_pkg::REQ_READ_EXT: begin
          s_next.rsp_data = s_reg.config_b;
        end
        secure_wp_pkg::REQ_GO_IDLE: begin
          s_next.config_b = secure_wp_pkg::CONFIG_BYTE_RESET;
        end
        default: begin
          s_next.rsp_ok = 1'b0;
          s_next.rsp_err = err_bit(secure_wp_pkg::ERR_GENERIC_POS);
        end
      endcase
    end
    s_next.secure = s_next.enable[secure_wp_pkg::ENABLE_BIT_POS];
    s_next.allow = s_next.config_b[secure_wp_pkg::UPDATE_BIT_POS];
    // temporary unprotect only while both set
    s_next.temp_unprot = s_next.secure & s_next.allow;
  end

  // reset means power loss or hardware reset; the enable byte's nonvolatile copy
  // lives outside this block and is restored by an authenticated write
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // group and boot state kept outside, never altered here
  assign o_req_busy = l_reg.busy;
  assign o_rsp_valid = l_reg.rsp_valid;
  assign o_rsp_ok = l_reg.rsp_ok;
  assign o_rsp_data = l_reg.rsp_data;
  assign o_rsp_err = l_reg.rsp_err;
  assign o_secure_mode = s_reg.secure;
  assign o_update_allow = s_reg.allow;
  assign o_temp_unprotect = s_reg.temp_unprot;
  assign o_erase_all = s_reg.erase_all;
  assign o_unlock = s_reg.unlock;

  // ****************************************
  // checks
  // ****************************************
  a_cfg_read_enable: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && l_reg.kind == secure_wp_pkg::REQ_CFG_READ && l_reg.auth
    && l_reg.addr == secure_wp_pkg::ENABLE_BYTE_OFFSET
    |=> s_reg.rsp_data == $past(s_reg.enable) && s_reg.rsp_ok)
    else $error("enable byte read answered wrong");

  a_unauth_write_dropped: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && l_reg.kind == secure_wp_pkg::REQ_CFG_WRITE && !l_reg.auth
    |=> $stable(s_reg.enable) && !s_reg.rsp_ok)
    else $error("unauthenticated write changed the enable byte");

  a_reserved_bits_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_reg.enable[7:1] == 7'h00 && s_reg.config_b[7:1] == 7'h00)
    else $error("reserved bits not zero");

  a_legacy_program_ok: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && !s_reg.secure && l_reg.kind == secure_wp_pkg::REQ_CSD_PROGRAM
    |=> s_reg.rsp_ok && s_reg.rsp_err == 3'h0)
    else $error("legacy program refused");

  a_locked_program_err: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && s_reg.secure && !s_reg.allow
    && l_reg.kind == secure_wp_pkg::REQ_CSD_PROGRAM
    |=> !s_reg.rsp_ok && s_reg.rsp_err[secure_wp_pkg::ERR_GENERIC_POS])
    else $error("program not refused with generic error");

  a_locked_switch_err: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && s_reg.secure && !s_reg.allow
    && l_reg.kind == secure_wp_pkg::REQ_SWITCH_PROTECT
    |=> s_reg.rsp_err == 3'h2)
    else $error("switch not refused with switch error");

  a_locked_group_err: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && s_reg.secure && !s_reg.allow
    && (l_reg.kind == secure_wp_pkg::REQ_SET_GROUP
    || l_reg.kind == secure_wp_pkg::REQ_CLEAR_GROUP)
    |=> s_reg.rsp_err == 3'h1)
    else $error("group command not refused");

  a_erase_refused: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && l_reg.kind == secure_wp_pkg::REQ_FORCE_ERASE
    && (!i_locked || (s_reg.secure && (!s_reg.allow || i_hard_groups_exist)))
    |=> s_reg.rsp_err == 3'h4 && !s_reg.erase_all && !s_reg.unlock)
    else $error("force erase not refused");

  a_erase_accepted: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && l_reg.kind == secure_wp_pkg::REQ_FORCE_ERASE && i_locked
    && s_reg.secure && s_reg.allow && !i_hard_groups_exist
    |=> s_reg.erase_all && s_reg.unlock ##1 !s_reg.erase_all && !s_reg.unlock)
    else $error("accepted erase not one pulse");

  a_idle_restores: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && l_reg.kind == secure_wp_pkg::REQ_GO_IDLE
    |=> !s_reg.temp_unprot && !s_reg.allow)
    else $error("soft reset left areas unprotected");

  a_unprot_needs_both: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_reg.temp_unprot |-> s_reg.enable[0] && s_reg.config_b[0])
    else $error("temporary unprotect without secure mode and update bit");

  a_enable_write_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && l_reg.kind == secure_wp_pkg::REQ_CFG_WRITE && l_reg.auth
    && l_reg.addr == secure_wp_pkg::ENABLE_BYTE_OFFSET
    |=> s_reg.enable == {7'h00, $past(l_reg.data[0])}
    && s_reg.secure == $past(l_reg.data[0]))
    else $error("authenticated enable write not applied");

  a_config_write_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && l_reg.kind == secure_wp_pkg::REQ_CFG_WRITE && l_reg.auth
    && l_reg.addr == secure_wp_pkg::CONFIG_BYTE_OFFSET
    |=> s_reg.config_b == {7'h00, $past(l_reg.data[0])}
    && s_reg.allow == $past(l_reg.data[0]))
    else $error("authenticated config write not applied");

  a_open_switch_ok: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && l_reg.kind == secure_wp_pkg::REQ_SWITCH_PROTECT
    && (!s_reg.secure || s_reg.allow)
    |=> s_reg.rsp_ok && s_reg.rsp_err == 3'h0)
    else $error("allowed protect switch refused");

  a_group_type_returned: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && l_reg.kind == secure_wp_pkg::REQ_SET_GROUP
    && (!s_reg.secure || s_reg.allow)
    |=> s_reg.rsp_ok
    && s_reg.rsp_data == {6'h00, $past(l_reg.data[2]), $past(l_reg.data[0])})
    else $error("group protection type not returned");

  a_ext_read_config: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    req_edge && l_reg.kind == secure_wp_pkg::REQ_READ_EXT
    |=> s_reg.rsp_data == $past(s_reg.config_b) && s_reg.rsp_ok)
    else $error("extended read did not return the config byte");

  a_no_stray_erase: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !req_edge |=> !s_reg.erase_all && !s_reg.unlock)
    else $error("erase or unlock pulse without a request");

endmodule

// ---- host_req_model.sv ----
// link-side host model issuing single-byte requests
`timescale 1ns/1ps
module host_req_model (
  input wire logic i_clk_link,
  input wire logic i_rsp_valid,
  input wire logic i_rsp_ok,
  input wire logic [7:0] i_rsp_data,
  input wire logic [2:0] i_rsp_err,
  output logic o_req_valid,
  output logic [3:0] o_req_kind,
  output logic o_req_auth,
  output logic [7:0] o_req_addr,
  output logic [7:0] o_req_data
);
  initial begin
    o_req_valid = 1'b0;
    o_req_kind = 4'h0;
    o_req_auth = 1'b0;
    o_req_addr = 8'h00;
    o_req_data = 8'h00;
  end

  // ****************************************
  // one request, then wait for its answer
  // ****************************************
  task automatic send(input logic [3:0] kind, input logic auth, input logic [7:0] addr,
                      input logic [7:0] data, output logic ok, output logic [7:0] rdata,
                      output logic [2:0] err, output logic got);
    int n;
    @(posedge i_clk_link);
    #1;
    o_req_valid = 1'b1;
    o_req_kind = kind;
    o_req_auth = auth;
    o_req_addr = addr;
    o_req_data = data;
    @(posedge i_clk_link);
    #1;
    o_req_valid = 1'b0;
    // released addr, data and auth lines never keep a stale value; the kind line keeps its value
    o_req_addr = ~addr;
    o_req_data = ~data;
    o_req_auth = ~auth;
    got = 1'b0;
    for (n = 0; n < 12 && !got; n++) begin
      @(posedge i_clk_link);
      #1;
      got = (i_rsp_valid === 1'b1);
    end
    ok = i_rsp_ok;
    rdata = i_rsp_data;
    err = i_rsp_err;
  endtask
endmodule

// ---- secure_write_protect_config_tb.sv ----
// self-checking bench for the secure write-protect control
`timescale 1ns/1ps
module secure_write_protect_config_tb;
  logic i_clk_sys;
  logic i_clk_link;
  logic i_rstn;
  logic i_req_valid;
  logic [3:0] i_req_kind;
  logic i_req_auth;
  logic [7:0] i_req_addr;
  logic [7:0] i_req_data;
  logic i_locked;
  logic i_hard_groups_exist;
  logic o_req_busy;
  logic o_rsp_valid;
  logic o_rsp_ok;
  logic [7:0] o_rsp_data;
  logic [2:0] o_rsp_err;
  logic o_secure_mode;
  logic o_update_allow;
  logic o_temp_unprotect;
  logic o_erase_all;
  logic o_unlock;
  int fail_count;
  int cmp_count;
  int cycles;
  int erase_n;
  int unlock_n;
  int busy_n;
  // row: kind, flags {auth,locked,groups,ok}, addr, data, read data, error, {secure,allow}
  logic [39:0] rows [28] = '{
    40'h0_D_01_00_00_0_0, 40'h0_D_02_00_00_0_0, 40'h2_D_00_00_00_0_0,
    40'h3_D_00_00_00_0_0, 40'h4_D_00_05_03_0_0, 40'h5_D_00_00_00_0_0,
    40'h1_D_01_FF_00_0_2, 40'h0_D_01_00_01_0_2, 40'h1_4_01_00_00_1_2,
    40'h0_C_03_00_00_1_2, 40'h2_C_00_00_00_1_2, 40'h3_C_00_00_00_2_2,
    40'h4_C_00_05_00_1_2, 40'h5_C_00_00_00_1_2, 40'h6_C_00_00_00_4_2,
    40'h1_D_02_FF_00_0_3, 40'h4_D_00_04_02_0_3, 40'h3_D_00_00_00_0_3,
    40'h2_D_00_00_00_0_3, 40'h7_D_00_00_01_0_3, 40'h6_8_00_00_00_4_3,
    40'h6_E_00_00_00_4_3, 40'h6_D_00_00_00_0_3, 40'h1_D_02_00_00_0_2,
    40'h1_D_02_01_00_0_3, 40'h8_D_00_00_00_0_2, 40'h0_D_02_00_00_0_2,
    40'h0_D_01_00_01_0_2};

  secure_wp_ctrl i_dut (
    .i_clk_sys, .i_rstn, .i_clk_link, .i_req_valid, .i_req_kind, .i_req_auth,
    .i_req_addr, .i_req_data, .i_locked, .i_hard_groups_exist, .o_req_busy,
    .o_rsp_valid, .o_rsp_ok, .o_rsp_data, .o_rsp_err, .o_secure_mode,
    .o_update_allow, .o_temp_unprotect, .o_erase_all, .o_unlock);

  host_req_model i_host (
    .i_clk_link, .i_rsp_valid(o_rsp_valid), .i_rsp_ok(o_rsp_ok),
    .i_rsp_data(o_rsp_data), .i_rsp_err(o_rsp_err), .o_req_valid(i_req_valid),
    .o_req_kind(i_req_kind), .o_req_auth(i_req_auth), .o_req_addr(i_req_addr),
    .o_req_data(i_req_data));

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  // link clock offset so edges never line up with the system clock
  initial begin
    i_clk_link = 1'b0;
    #7.3;
    forever #24 i_clk_link = ~i_clk_link;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // pulse counters and hang limit
  // ****************************************
  always @(posedge i_clk_sys) begin
    cycles++;
    if (o_erase_all === 1'b1) begin
      erase_n++;
    end
    if (o_unlock === 1'b1) begin
      unlock_n++;
    end
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  always @(posedge i_clk_link) begin
    if (o_req_busy === 1'b1) begin
      busy_n++;
    end
  end

  // ****************************************
  // table run, then reset in mid-run
  // ****************************************
  initial begin
    logic ok;
    logic [7:0] rd;
    logic [2:0] err;
    logic got;
    logic [39:0] r;
    int busy_was;
    i_rstn = 1'b0;
    i_locked = 1'b1;
    i_hard_groups_exist = 1'b0;
    repeat (20) @(posedge i_clk_sys);
    #1;
    i_rstn = 1'b1;
    repeat (2) @(posedge i_clk_link);
    #1;
    foreach (rows[i]) begin
      r = rows[i];
      i_locked = r[34];
      i_hard_groups_exist = r[33];
      busy_was = busy_n;
      i_host.send(r[39:36], r[35], r[31:24], r[23:16], ok, rd, err, got);
      check({7'h0, got}, 8'h01, "answer");
      check({7'h0, o_req_busy}, 8'h00, "busy after answer");
      check({7'h0, busy_n > busy_was}, 8'h01, "busy in flight");
      check({7'h0, ok}, {7'h0, r[32]}, "accept");
      check(rd, r[15:8], "read data");
      check({5'h0, err}, {5'h0, r[6:4]}, "error");
      check({6'h0, o_secure_mode, o_update_allow}, {6'h0, r[1:0]}, "mode");
      check({7'h0, o_temp_unprotect}, {7'h0, r[1] & r[0]}, "temp");
      $display("row %0d done", i);
    end
    check(erase_n[7:0], 8'h01, "erase pulses");
    check(unlock_n[7:0], 8'h01, "unlock pulses");
    i_host.send(4'h1, 1'b1, 8'h02, 8'h01, ok, rd, err, got);
    check({7'h0, o_temp_unprotect}, 8'h01, "temp before reset");
    @(posedge i_clk_sys);
    #1;
    i_rstn = 1'b0;
    repeat (20) @(posedge i_clk_sys);
    check({5'h0, o_secure_mode, o_update_allow, o_temp_unprotect}, 8'h00, "in reset");
    #1;
    i_rstn = 1'b1;
    repeat (2) @(posedge i_clk_link);
    #1;
    i_host.send(4'h0, 1'b1, 8'h01, 8'h00, ok, rd, err, got);
    check(rd, 8'h00, "enable after reset");
    i_host.send(4'h5, 1'b1, 8'h00, 8'h00, ok, rd, err, got);
    check({7'h0, ok}, 8'h01, "legacy clear group");
    $display("reset test done");
    i_host.send(4'h0, 1'b0, 8'h01, 8'h00, ok, rd, err, got);
    check({5'h0, err}, 8'h01, "unauthenticated read");
    check(rd, 8'h00, "unauthenticated read data");
    i_host.send(4'h9, 1'b1, 8'h00, 8'h00, ok, rd, err, got);
    check({5'h0, err}, 8'h01, "unknown request");
    check({7'h0, ok}, 8'h00, "unknown refused");
    $display("awkward cases done");
    results();
  end
endmodule
